// ---- core/bsi_regs.svh ----
`ifndef BSI_REGS_SVH
`define BSI_REGS_SVH
`define BSI_IR_LEN        4
`define BSI_OP_EXTEST     4'h0
`define BSI_OP_SAMPLE     4'h1
`define BSI_OP_IDCODE     4'h2
`define BSI_OP_USERCODE   4'h3
`define BSI_OP_CLAMP      4'h4
`define BSI_OP_PGM_ENTER  4'h8
`define BSI_OP_PGM_DATA   4'h9
`define BSI_OP_PGM_DONE   4'hA
`define BSI_OP_PGM_EXIT   4'hB
`define BSI_OP_BYPASS     4'hF
`define BSI_IR_CAPTURE    4'h1
`define BSI_DR_LEN        32
`define BSI_ID_DEFAULT    32'h0000_0001
`endif

// ---- core/bsi_pkg.sv ----
package bsi_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } bsi_tap_t;
endpackage

// ---- core/bsi_top.sv ----
// What this block does
// [R1] Sample/preload captures pins, preloads pattern
// [R2] Extest drives outputs, captures inputs
// [R3] Bypass: one-bit stage between TDI, TDO
// [R4] Clamp holds pins, bypass path
// [R5] Idcode shifts identification register out
// [R6] Usercode shifts 32-bit signature out
// [R7] Unused test port becomes user pins; scan_en_i low only releases TDO, TCK/TMS/TDI still drive the controller
// [R8] Programming instructions through same port
// [R9] Pins tri-stated, pulled high while programming
// [R10] No pin drives before completion flag
// [R11] Sixteen-state controller on clock, mode
// [R12] Identification is 32 bits, LSB one
`timescale 1ns/10ps
`include "bsi_regs.svh"
module bsi_top #(
    parameter int          NPIN     = 8,
    parameter logic [31:0] ID_VALUE = `BSI_ID_DEFAULT // arbitrary value
) (
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            tck_i,
    input  wire logic            tms_i,
    input  wire logic            tdi_i,
    input  wire logic            scan_en_i,
    input  wire logic [NPIN-1:0] core_out_i,
    input  wire logic [NPIN-1:0] core_oe_i,
    input  wire logic [NPIN-1:0] pin_in_i,
    input  wire logic            rx_ready_i,
    output logic      [NPIN-1:0] pin_out_o,
    output logic      [NPIN-1:0] pin_oe_o,
    output logic      [NPIN-1:0] pin_pullup_o,
    output logic      [NPIN-1:0] core_in_o,
    output logic                 tdo_o,
    output logic                 tdo_oe_o,
    output logic                 pgm_active_o,
    output logic                 pgm_done_o,
    output logic                 rx_valid_o,
    output logic      [31:0]     rx_data_o
);
    // Zero padding of the boundary word needs NPIN below half the register
    if (NPIN < 1 || 2 * NPIN >= `BSI_DR_LEN) begin : g_bad_npin
        $error("NPIN out of range");
    end
    if (ID_VALUE[0] != 1'b1) begin : g_bad_id
        $error("ID_VALUE bit 0 must be one");
    end

    localparam int BLEN = 2 * NPIN;

    // Pin sync: two flops before use
    logic [2:0] s1_ff, s2_ff;
    logic       tck_d_ff;
    logic [NPIN-1:0] pin_s1_ff, pin_s2_ff;
    always_ff @(posedge clk_i) begin
        s1_ff     <= {tck_i, tms_i, tdi_i};
        s2_ff     <= s1_ff;
        pin_s1_ff <= pin_in_i;
        pin_s2_ff <= pin_s1_ff;
        tck_d_ff  <= s2_ff[2];
    end
    wire tck_s   = s2_ff[2];
    wire tms_s   = s2_ff[1];
    wire tdi_s   = s2_ff[0];
    wire tck_ris = tck_s & ~tck_d_ff;
    wire tck_fal = ~tck_s & tck_d_ff;

    bsi_pkg::bsi_tap_t st_ff, nxt_st;
    // [R11] standard state sequencing
    always_comb begin
        unique case (st_ff)
            bsi_pkg::TLR:    nxt_st = tms_s ? bsi_pkg::TLR    : bsi_pkg::RTI;
            bsi_pkg::RTI:    nxt_st = tms_s ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
            bsi_pkg::SEL_DR: nxt_st = tms_s ? bsi_pkg::SEL_IR : bsi_pkg::CAP_DR;
            bsi_pkg::CAP_DR: nxt_st = tms_s ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
            bsi_pkg::SH_DR:  nxt_st = tms_s ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
            bsi_pkg::EX1_DR: nxt_st = tms_s ? bsi_pkg::UP_DR  : bsi_pkg::PA_DR;
            bsi_pkg::PA_DR:  nxt_st = tms_s ? bsi_pkg::EX2_DR : bsi_pkg::PA_DR;
            bsi_pkg::EX2_DR: nxt_st = tms_s ? bsi_pkg::UP_DR  : bsi_pkg::SH_DR;
            bsi_pkg::UP_DR:  nxt_st = tms_s ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
            bsi_pkg::SEL_IR: nxt_st = tms_s ? bsi_pkg::TLR    : bsi_pkg::CAP_IR;
            bsi_pkg::CAP_IR: nxt_st = tms_s ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
            bsi_pkg::SH_IR:  nxt_st = tms_s ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
            bsi_pkg::EX1_IR: nxt_st = tms_s ? bsi_pkg::UP_IR  : bsi_pkg::PA_IR;
            bsi_pkg::PA_IR:  nxt_st = tms_s ? bsi_pkg::EX2_IR : bsi_pkg::PA_IR;
            bsi_pkg::EX2_IR: nxt_st = tms_s ? bsi_pkg::UP_IR  : bsi_pkg::SH_IR;
            bsi_pkg::UP_IR:  nxt_st = tms_s ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
        endcase
    end

    logic [`BSI_IR_LEN-1:0] ir_sh_ff, ir_ff;
    logic [`BSI_DR_LEN-1:0] dr_ff, bnd_upd_ff, user_ff;
    logic                   pgm_ff, done_ff, tdo_ff, tdo_oe_ff;

    wire in_shdr = (st_ff == bsi_pkg::SH_DR);
    wire in_shir = (st_ff == bsi_pkg::SH_IR);
    wire op_ext  = (ir_ff == `BSI_OP_EXTEST);
    wire op_smp  = (ir_ff == `BSI_OP_SAMPLE);
    wire op_id   = (ir_ff == `BSI_OP_IDCODE);
    wire op_usr  = (ir_ff == `BSI_OP_USERCODE);
    wire op_clp  = (ir_ff == `BSI_OP_CLAMP);
    wire op_pdat = (ir_ff == `BSI_OP_PGM_DATA);
    wire op_bnd  = op_ext | op_smp;
    wire op_wide = op_bnd | op_id | op_usr | op_pdat;
    // [R3] single-stage bypass unless a wide register is chosen
    wire [5:0] dr_len = op_bnd ? 6'(BLEN) : (op_wide ? 6'd32 : 6'd1);
    wire [`BSI_DR_LEN-1:0] bnd_cap = {{(`BSI_DR_LEN-BLEN){1'b0}}, core_out_i, pin_s2_ff};
    // [R5] identification selected; [R12] LSB fixed at one
    wire [`BSI_DR_LEN-1:0] cap_val = op_bnd ? bnd_cap :
                                     op_id  ? {ID_VALUE[31:1], 1'b1} :
                                     op_usr ? user_ff : '0;
    wire [`BSI_DR_LEN-1:0] dr_shift = (dr_ff >> 1) | ({{(`BSI_DR_LEN-1){1'b0}}, tdi_s} << (dr_len - 6'd1));

    logic buf_ready;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_ff <= bsi_pkg::TLR;
            ir_ff <= `BSI_OP_BYPASS;
            ir_sh_ff <= '0;
            dr_ff <= '0;
            bnd_upd_ff <= '0;
            pgm_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (tck_ris) begin
            st_ff <= nxt_st;
            if (st_ff == bsi_pkg::TLR) ir_ff <= `BSI_OP_BYPASS;
            if (st_ff == bsi_pkg::CAP_IR) ir_sh_ff <= `BSI_IR_CAPTURE;
            if (in_shir) ir_sh_ff <= {tdi_s, ir_sh_ff[`BSI_IR_LEN-1:1]};
            if (st_ff == bsi_pkg::UP_IR) ir_ff <= ir_sh_ff;
            // [R1] capture pins without disturbing user path
            if (st_ff == bsi_pkg::CAP_DR) dr_ff <= cap_val;
            if (in_shdr) dr_ff <= dr_shift;
            // [R1] preload pattern latched on update
            if (st_ff == bsi_pkg::UP_DR && op_bnd) bnd_upd_ff <= dr_ff;
            // [R8] programming instruction group
            if (st_ff == bsi_pkg::UP_IR && ir_sh_ff == `BSI_OP_PGM_ENTER) begin
                pgm_ff <= 1'b1;
                done_ff <= 1'b0;
            end
            if (st_ff == bsi_pkg::UP_IR && ir_sh_ff == `BSI_OP_PGM_DONE && pgm_ff) done_ff <= 1'b1;
            if (st_ff == bsi_pkg::UP_IR && ir_sh_ff == `BSI_OP_PGM_EXIT) pgm_ff <= 1'b0;
        end
    end

    // [R6] signature loaded from programmed data word
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) user_ff <= '0;
        else if (tck_ris && pgm_ff && st_ff == bsi_pkg::UP_DR && op_pdat) user_ff <= dr_ff;
    end

    // TDO changes on falling TCK
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fal) begin
            tdo_ff <= in_shir ? ir_sh_ff[0] : dr_ff[0];
            tdo_oe_ff <= scan_en_i & (in_shir | in_shdr);
        end else if (!scan_en_i) begin
            tdo_oe_ff <= 1'b0;
        end
    end

    // [R2] boundary drives pins; [R4] clamp holds them
    wire bnd_drive = op_ext | op_clp;
    // [R9] [R10] no drive while programming or before done
    wire pin_hold  = pgm_ff | ~done_ff;
    wire [NPIN-1:0] nxt_out = bnd_drive ? bnd_upd_ff[2*NPIN-1:NPIN] : core_out_i;
    wire [NPIN-1:0] nxt_oe  = pin_hold ? '0 : (bnd_drive ? {NPIN{1'b1}} : core_oe_i);
    // [R2] extest isolates core from captured inputs
    wire [NPIN-1:0] nxt_cin = op_ext ? bnd_upd_ff[NPIN-1:0] : pin_s2_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_out_o <= '0;
            pin_oe_o <= '0;
            pin_pullup_o <= '1;
            core_in_o <= '0;
        end else begin
            pin_out_o <= nxt_out;
            pin_oe_o <= nxt_oe;
            pin_pullup_o <= {NPIN{pgm_ff | ~done_ff}};
            core_in_o <= nxt_cin;
        end
    end
    // [R7] TDO pin free when scan disabled
    assign tdo_o = tdo_ff;
    assign tdo_oe_o = tdo_oe_ff;
    assign pgm_active_o = pgm_ff;
    assign pgm_done_o = done_ff;

    // Two-entry buffer for programmed data words
    logic [31:0] b0_ff, b1_ff;
    logic [1:0]  cnt_ff;
    logic        vld_ff;
    wire push = tck_ris && pgm_ff && st_ff == bsi_pkg::UP_DR && op_pdat && buf_ready;
    wire pop  = rx_valid_o & rx_ready_i;
    wire [1:0] nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
    assign buf_ready = (cnt_ff != 2'd2);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 2'd0;
            vld_ff <= 1'b0;
            b0_ff <= '0;
            b1_ff <= '0;
        end else begin
            if (pop) b0_ff <= b1_ff;
            if (push && (cnt_ff == 2'd0 || (cnt_ff == 2'd1 && pop))) b0_ff <= dr_ff;
            else if (push) b1_ff <= dr_ff;
            cnt_ff <= nxt_cnt;
            // Valid kept in its own flop so the output leaves a register directly
            vld_ff <= (nxt_cnt != 2'd0);
        end
    end
    assign rx_valid_o = vld_ff;
    assign rx_data_o = b0_ff;

    // [R10] outputs off until done
    AST_NO_DRIVE_EARLY: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
        !$past(done_ff) |-> pin_oe_o == '0) else $error("pin driven before done");
    // [R9] programming tri-states
    AST_PGM_TRI: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        $past(pgm_ff) |-> (pin_oe_o == '0 && pin_pullup_o == '1)) else $error("pin driven in pgm");
    // [R11] reset state
    AST_TLR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        (tck_ris && tms_s && st_ff == bsi_pkg::SEL_IR) |=> st_ff == bsi_pkg::TLR) else $error("tap seq");
    // [R12] idcode capture
    AST_IDCAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
        (tck_ris && op_id && st_ff == bsi_pkg::CAP_DR) |=> dr_ff[0] == 1'b1) else $error("id lsb");
    // [R3] bypass capture zero
    AST_BYP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
        (tck_ris && ir_ff == `BSI_OP_BYPASS && st_ff == bsi_pkg::CAP_DR) |=> dr_ff == '0) else $error("bypass");
    // [R4] clamp drive
    AST_CLAMP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
        (op_clp && !pin_hold) |=> pin_out_o == $past(bnd_upd_ff[2*NPIN-1:NPIN])) else $error("clamp");
    // [R1] sample keeps user path
    AST_SAMPLE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
        (op_smp && !pin_hold) |=> pin_oe_o == $past(core_oe_i)) else $error("sample disturbed");
    // [R8] entry sets active
    AST_PGM_ENTER: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
        (tck_ris && st_ff == bsi_pkg::UP_IR && ir_sh_ff == `BSI_OP_PGM_ENTER) |=> pgm_ff) else $error("pgm enter");
    // [R7] pin free when off
    AST_TDO_FREE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
        !scan_en_i |=> !tdo_oe_o) else $error("tdo driven");
    // [R7] port drives while shifting
    AST_TDO_ON: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
        (tck_fal && scan_en_i && in_shdr) |=> tdo_oe_o) else $error("tdo not driven in shift");
    // [R8] head word holds while stalled
    AST_BUF_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
        (rx_valid_o && !rx_ready_i) |=> (rx_valid_o && $stable(rx_data_o))) else $error("buffer head lost");
    // [R8] buffer never over two
    AST_BUF_LIMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
        cnt_ff <= 2'd2) else $error("buffer count overflow");
    // [R8] exit clears active
    AST_PGM_EXIT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
        (tck_ris && st_ff == bsi_pkg::UP_IR && ir_sh_ff == `BSI_OP_PGM_EXIT) |=> !pgm_ff) else $error("pgm exit");
    // [R2] extest drives outputs
    AST_EXT_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
        (op_ext && !pin_hold) |=> (pin_out_o == $past(bnd_upd_ff[2*NPIN-1:NPIN]) && pin_oe_o == '1))
        else $error("extest drive");
    // [R2] extest isolates core
    AST_EXT_CIN: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
        op_ext |=> core_in_o == $past(bnd_upd_ff[NPIN-1:0])) else $error("extest core input");
    // [R1] sample passes pins
    AST_SMP_CIN: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
        op_smp |=> core_in_o == $past(pin_s2_ff)) else $error("sample core input");
    // [R1] boundary capture value
    AST_BND_CAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
        (tck_ris && op_bnd && st_ff == bsi_pkg::CAP_DR) |=> dr_ff == $past(bnd_cap)) else $error("boundary capture");
    // [R6] signature capture value
    AST_USR_CAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        (tck_ris && op_usr && st_ff == bsi_pkg::CAP_DR) |=> dr_ff == $past(user_ff)) else $error("usercode capture");
    // [R6] signature loaded from data
    AST_USR_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        (tck_ris && pgm_ff && st_ff == bsi_pkg::UP_DR && op_pdat) |=> user_ff == $past(dr_ff))
        else $error("usercode load");
    // [R5] full identification captured
    AST_ID_VAL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
        (tck_ris && op_id && st_ff == bsi_pkg::CAP_DR) |=> dr_ff == {ID_VALUE[31:1], 1'b1}) else $error("id value");
    // [R11] instruction update
    AST_IR_UPD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        (tck_ris && st_ff == bsi_pkg::UP_IR) |=> ir_ff == $past(ir_sh_ff)) else $error("ir update");
    // [R11] instruction capture pattern
    AST_IR_CAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        (tck_ris && st_ff == bsi_pkg::CAP_IR) |=> ir_sh_ff == `BSI_IR_CAPTURE) else $error("ir capture");
    // [R11] reset state selects bypass
    AST_TLR_IR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        (tck_ris && st_ff == bsi_pkg::TLR) |=> ir_ff == `BSI_OP_BYPASS) else $error("reset instruction");
    // [R10] done set by final step
    AST_DONE_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
        (tck_ris && st_ff == bsi_pkg::UP_IR && ir_sh_ff == `BSI_OP_PGM_DONE && pgm_ff) |=> done_ff)
        else $error("done not set");
    // [R10] user control after done
    AST_USER_OE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
        (!pin_hold && !bnd_drive) |=> pin_oe_o == $past(core_oe_i)) else $error("user enable lost");
    // [R9] pull-ups off in user mode
    AST_PULL_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        (!$past(pgm_ff) && $past(done_ff)) |-> pin_pullup_o == '0) else $error("pull-up left on");
    // [R4] clamp drives all pins
    AST_CLAMP_OE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
        (op_clp && !pin_hold) |=> pin_oe_o == '1) else $error("clamp enable");
    // [R4] clamp serial path is bypass
    AST_CLAMP_BYP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
        (tck_ris && op_clp && st_ff == bsi_pkg::CAP_DR) |=> dr_ff == '0) else $error("clamp path");
    // [R3] bypass stage takes TDI
    AST_BYP_SHIFT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
        (tck_ris && in_shdr && dr_len == 6'd1) |=> dr_ff[0] == $past(tdi_s)) else $error("bypass shift");
    // [R3] TDO shows low stage
    AST_TDO_SHIFT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
        (tck_fal && in_shdr) |=> tdo_o == $past(dr_ff[0])) else $error("tdo bit");
endmodule // bsi_top

// ---- tb/bsi_ctl_model.sv ----
`timescale 1ns/10ps
module bsi_ctl_model (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // TDO is launched on the fall, so it is taken just before the rise
    task automatic cyc(input logic ms, input logic di, output logic so);
        tms_o = ms;
        tdi_o = di;
        #400;
        so = tdo_i;
        tck_o = 1'b1;
        #400;
        tck_o = 1'b0;
    endtask
    task automatic tap_reset();
        logic s;
        #13;
        repeat (5) cyc(1'b1, 1'b0, s);
        cyc(1'b0, 1'b0, s);
    endtask
    task automatic walk(input int n, input logic ir, input logic [31:0] din, output logic [31:0] dout);
        logic s;
        dout = '0;
        #13;
        cyc(1'b1, 1'b0, s);
        if (ir) cyc(1'b1, 1'b0, s);
        cyc(1'b0, 1'b0, s);
        cyc(1'b0, 1'b0, s);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, din[i], s);
            dout[i] = s;
        end
        cyc(1'b1, 1'b0, s);
        cyc(1'b0, 1'b0, s);
    endtask
endmodule // bsi_ctl_model

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`include "bsi_regs.svh"
module testbench;
    // Arbitrary identity value with its low bit set
    localparam logic [31:0] ID_VAL = 32'h1234_5679;
    logic        clk_i, rst_n_i, scan_en_i, rx_ready_i, tck, tms, tdi, tdo_o, tdo_oe_o;
    logic        pgm_active_o, pgm_done_o, rx_valid_o;
    logic [7:0]  core_out_i, core_oe_i, pin_in_i, pin_out_o, pin_oe_o, pin_pullup_o, core_in_o;
    logic [31:0] rx_data_o, d;
    int          n_fail = 0;
    int          checks = 0;
    bsi_top #(.NPIN(8), .ID_VALUE(ID_VAL)) u_bsi_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .scan_en_i(scan_en_i), .core_out_i(core_out_i), .core_oe_i(core_oe_i),
        .pin_in_i(pin_in_i), .rx_ready_i(rx_ready_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .pin_pullup_o(pin_pullup_o), .core_in_o(core_in_o), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .pgm_active_o(pgm_active_o), .pgm_done_o(pgm_done_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o));
    bsi_ctl_model u_bsi_ctl_model (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ir(input logic [3:0] op);
        logic [31:0] c;
        u_bsi_ctl_model.walk(4, 1'b1, {28'h0, op}, c);
        check(c[3:0], `BSI_IR_CAPTURE);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        u_bsi_ctl_model.walk(n, 1'b0, din, dout);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic pop();
        @(posedge clk_i) rx_ready_i <= 1'b1;
        @(posedge clk_i) rx_ready_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic t_id_bypass();
        check(pin_oe_o, 8'h00);
        ir(`BSI_OP_IDCODE);
        dr(32, 32'h0, d);
        check(d, ID_VAL);
        check(d[0], 1'b1);
        ir(`BSI_OP_BYPASS);
        dr(8, 32'hB5, d);
        check(d[7:0], 8'h6A);
    endtask
    // Third word arrives with both entries full and no consumer
    task automatic t_pgm();
        ir(`BSI_OP_PGM_ENTER);
        check({pgm_active_o, pgm_done_o}, 2'b10);
        check({pin_oe_o, pin_pullup_o}, 16'h00FF);
        ir(`BSI_OP_PGM_DATA);
        dr(32, 32'hA1B2_C3D4, d);
        dr(32, 32'h5E6F_7081, d);
        dr(32, 32'h0F0F_F0F0, d);
        check({rx_valid_o, rx_data_o}, {1'b1, 32'hA1B2_C3D4});
        pop();
        check({rx_valid_o, rx_data_o}, {1'b1, 32'h5E6F_7081});
        pop();
        check(rx_valid_o, 1'b0);
        @(posedge clk_i) rx_ready_i <= 1'b1;
        dr(32, 32'h9ABC_DEF1, d);
        @(posedge clk_i) rx_ready_i <= 1'b0;
        ir(`BSI_OP_PGM_DONE);
        check({pgm_done_o, pin_oe_o}, 9'h100);
        ir(`BSI_OP_PGM_EXIT);
        check({pgm_active_o, pin_oe_o, pin_out_o}, {1'b0, core_oe_i, core_out_i});
        ir(`BSI_OP_USERCODE);
        dr(32, 32'h0, d);
        check(d, 32'h9ABC_DEF1);
    endtask
    task automatic t_bscan();
        ir(`BSI_OP_SAMPLE);
        dr(16, 32'h9600, d);
        check(d[7:0], 8'hA5);
        check({core_in_o, pin_out_o}, 16'hA53C);
        ir(`BSI_OP_EXTEST);
        check(pin_out_o, 8'h96);
        @(posedge clk_i) pin_in_i <= 8'h5A;
        dr(16, 32'h9600, d);
        check(d[7:0], 8'h5A);
        ir(`BSI_OP_CLAMP);
        dr(4, 32'hB, d);
        check({pin_out_o, d[3:0]}, 12'h966);
    endtask
    task automatic t_free();
        @(posedge clk_i) scan_en_i <= 1'b0;
        dr(8, 32'h55, d);
        check(tdo_oe_o, 1'b0);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #2_000_000;
        n_fail++;
        print_verdict();
    end
    initial begin
        {rst_n_i, rx_ready_i, scan_en_i} = 3'b001;
        {core_out_i, core_oe_i, pin_in_i} = 24'h3CFF_A5;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        u_bsi_ctl_model.tap_reset();
        t_id_bypass();
        t_pgm();
        t_bscan();
        t_free();
        print_verdict();
    end
endmodule // testbench
